// [rtl/ecc_page_tracker.sv]
/*
  Small memory of per-page program counts used to predict whether the
  flash still corrects errors on a page. Reads are combinational; the flag is registered.
  Assumes one access per clock from the bus controller.
*/
`timescale 1ns/100ps
module ecc_page_tracker #(
  parameter int PAGES_W = 6
) (
  input  wire logic               mclk,       // System clock
  input  wire logic               nrst,       // Synchronous reset, active low
  input  wire logic               prog_hit,   // Page programmed this cycle
  input  wire logic               erase_all,  // Forget all history
  input  wire logic [PAGES_W-1:0] page_idx,   // Page index
  output logic                    ecc_off_ff  // Page has been programmed twice
);
  import flash_host_pkg::*;

  logic [1:0] cnt_mem [2**PAGES_W];
  logic [1:0] cur;

  assign cur = cnt_mem[page_idx];

  // Count saturates at two; a second program turns correction off
  always_ff @(posedge mclk) begin
    if (!nrst || erase_all) begin
      for (int i = 0; i < 2**PAGES_W; i++) cnt_mem[i] <= 2'h0;
      ecc_off_ff <= 1'b0;
    end else begin
      if (prog_hit && cur != 2'h2) cnt_mem[page_idx] <= cur + 2'h1;
      ecc_off_ff <= (cur == 2'h2) || (prog_hit && cur == 2'h1);
    end
  end
endmodule : ecc_page_tracker

// [rtl/flash_bus_ctrl.sv]
/*
  Host-side controller for an asynchronous parallel NOR flash.
  Takes one request at a time on a valid/ready port and walks the
  flash pins through read, write and command sequences.
  Assumes the flash data pins are resolved outside from the enables.
*/
`timescale 1ns/100ps
module flash_bus_ctrl
  import flash_host_pkg::*;
#(
  parameter int TRACK_W = 6
) (
  input  wire logic                  mclk,        // System clock
  input  wire logic                  nrst,        // Synchronous reset, active low
  input  wire flash_host_pkg::req_s  req,         // Request
  input  wire logic                  req_valid,   // Request offered
  output logic                       req_ready,   // Request taken
  output logic [15:0]                rd_data_ff,  // Read data
  output logic                       rd_valid_ff, // One-cycle read done pulse
  output logic                       wr_done_ff,  // One-cycle write done pulse
  output logic                       ecc_off,     // Page of the last accepted request lost correction
  input  wire logic                  accel_req,   // Ask for accelerated programming
  output logic                       accel_pin_ff,// High-voltage enable on accel pin
  output flash_host_pkg::pins_s      pins_ff,     // Control and address pins
  output logic [15:0]                dq_out_ff,   // Data pin drive value
  output logic [15:0]                dq_oe_n_ff,  // Data pin enable, low drives
  input  wire logic [15:0]           dq_in        // Data pin level
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD   = 3'b001,
    ST_WR   = 3'b011,
    ST_REC  = 3'b010,
    ST_DONE = 3'b110
  } st_e;

  st_e                 st_ff, nxt_st;
  req_s                cur_ff;
  logic [CNT_W-1:0]    cnt_ff;
  logic [1:0]          step_ff;
  logic [ADDR_W-1:0]   last_page_ff;
  logic                page_ok_ff;
  logic                prog_hit;

  // Address and data of a sequence step; unlock cycles first
  function automatic logic [ADDR_W+15:0] seq_word(input req_s r, input logic [1:0] s);
    logic [ADDR_W+15:0] w;
    w = {r.addr[ADDR_W:1], r.data};
    if (r.op == OP_PROG || r.op == OP_IDENT) begin
      case (s)
        2'h0: w = {UNL_A1[ADDR_W-1:0], UNL_D1};
        2'h1: w = {UNL_A2[ADDR_W-1:0], UNL_D2};
        2'h2: w = {UNL_A1[ADDR_W-1:0], (r.op == OP_IDENT) ? CMD_IDENT : CMD_PROG};
        default: w = {r.addr[ADDR_W:1], r.data};
      endcase
    end
    return w;
  endfunction : seq_word

  wire logic [1:0] first_step = (cur_ff.op == OP_PROG && (cur_ff.short_prog || accel_pin_ff))
                                ? 2'h2 : 2'h0;
  wire logic [1:0] last_step  = (cur_ff.op == OP_PROG) ? 2'h3 :
                                (cur_ff.op == OP_IDENT) ? 2'h2 : 2'h0;
  // Short program skips the unlock cycles; the step is latched on the edge where the strobe falls
  wire logic [1:0] eff_step = (step_ff < first_step) ? first_step : step_ff;
  wire logic [ADDR_W+15:0] sw = seq_word(cur_ff, eff_step);
  // Same page and select still low gives page time, else full time
  wire logic same_page = page_ok_ff &&
       (last_page_ff[ADDR_W-1:PAGE_LSB] == cur_ff.addr[ADDR_W:PAGE_LSB+1]);
  wire logic [CNT_W-1:0] rd_cyc = same_page ? CNT_W'(PAGE_CYC) : CNT_W'(FULL_CYC);
  wire logic cnt_end = (cnt_ff == '0);

  assign req_ready = (st_ff == ST_IDLE);
  assign prog_hit  = (st_ff == ST_WR) && cnt_end && !pins_ff.nwe && (step_ff == last_step) &&
                     (cur_ff.op == OP_PROG);

  // Next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (req_valid) nxt_st = (req.op == OP_READ) ? ST_RD : ST_WR;
      ST_RD:   if (!pins_ff.noe && cnt_end) nxt_st = ST_DONE;
      ST_WR:   if (!pins_ff.nwe && cnt_end) nxt_st = ST_REC;
      ST_REC:  if (cnt_end) nxt_st = (step_ff == last_step) ? ST_DONE : ST_WR;
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // Sequencer; select stays low between reads for page mode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_ff        <= ST_IDLE;
      cur_ff       <= '0;
      cnt_ff       <= '0;
      step_ff      <= 2'h0;
      page_ok_ff   <= 1'b0;
      last_page_ff <= '0;
      rd_data_ff   <= 16'h0000;
      rd_valid_ff  <= 1'b0;
      wr_done_ff   <= 1'b0;
      pins_ff      <= '{nce: 1'b1, noe: 1'b1, nwe: 1'b1, byte_sel: 1'b1, addr: '0};
      dq_out_ff    <= 16'h0000;
      dq_oe_n_ff   <= 16'hFFFF;
    end else begin
      st_ff       <= nxt_st;
      rd_valid_ff <= 1'b0;
      wr_done_ff  <= 1'b0;
      if (cnt_ff != '0) cnt_ff <= cnt_ff - CNT_W'(1);
      case (st_ff)
        ST_IDLE: if (req_valid) begin
          cur_ff <= req;
          // Width change forces a deselect first
          if (req.byte_mode == pins_ff.byte_sel) begin
            page_ok_ff  <= 1'b0;
            pins_ff.nce <= 1'b1;
          end
          pins_ff.byte_sel <= ~req.byte_mode;
        end
        ST_RD: begin
          // Count starts as the gate falls; the spare cycle covers input setup
          if (pins_ff.noe) cnt_ff <= rd_cyc;
          pins_ff.nce  <= 1'b0;
          pins_ff.noe  <= 1'b0;
          pins_ff.nwe  <= 1'b1;
          pins_ff.addr <= cur_ff.addr[ADDR_W:1];
          // Top data line carries the byte address bit in byte mode
          dq_oe_n_ff   <= cur_ff.byte_mode ? 16'h7FFF : 16'hFFFF;
          dq_out_ff    <= {cur_ff.addr[0], 15'h0000};
          if (pins_ff.nce) page_ok_ff <= 1'b0;
          if (!pins_ff.noe && cnt_end) begin
            rd_data_ff   <= cur_ff.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
            rd_valid_ff  <= 1'b1;
            page_ok_ff   <= 1'b1;
            last_page_ff <= cur_ff.addr[ADDR_W:1];
            pins_ff.noe  <= 1'b1;
          end
        end
        ST_WR: begin
          if (pins_ff.nwe) begin
            cnt_ff <= CNT_W'(WE_CYC);
            step_ff <= eff_step;
          end
          pins_ff.nce  <= 1'b0;
          pins_ff.noe  <= 1'b1;
          pins_ff.nwe  <= cnt_end && !pins_ff.nwe;
          pins_ff.addr <= sw[ADDR_W+15:16];
          dq_out_ff    <= sw[15:0];
          dq_oe_n_ff   <= cur_ff.byte_mode ? 16'hFF00 : 16'h0000;
          page_ok_ff   <= 1'b0;
          if (cnt_end && !pins_ff.nwe) cnt_ff <= CNT_W'(REC_CYC);
        end
        ST_REC: begin
          pins_ff.nce <= 1'b1;
          dq_oe_n_ff  <= 16'hFFFF;
          if (cnt_end && step_ff != last_step) step_ff <= step_ff + 2'h1;
        end
        ST_DONE: begin
          step_ff <= 2'h0;
          if (cur_ff.op != OP_READ) wr_done_ff <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // High voltage only while a program request waits or runs
  always_ff @(posedge mclk) begin
    if (!nrst) accel_pin_ff <= 1'b0;
    else accel_pin_ff <= accel_req && (st_ff == ST_IDLE ? (req_valid && req.op == OP_PROG)
                                                        : cur_ff.op == OP_PROG);
  end

  // Tracks which pages lost correction by repeat programming
  ecc_page_tracker #(.PAGES_W(TRACK_W)) u_track (
    .mclk      (mclk),
    .nrst      (nrst),
    .prog_hit  (prog_hit),
    .erase_all (1'b0),
    .page_idx  (cur_ff.addr[ECC_PAGE_LSB+TRACK_W:ECC_PAGE_LSB+1]),
    .ecc_off_ff(ecc_off)
  );

  property p_rd_pins;
    @(posedge mclk) disable iff (!nrst) !pins_ff.noe |-> pins_ff.nwe && !pins_ff.nce;
  endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read without write high");

  property p_wr_pins;
    @(posedge mclk) disable iff (!nrst) !pins_ff.nwe |-> pins_ff.noe && !pins_ff.nce;
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("write without gate high");

  property p_byte_hold;
    @(posedge mclk) disable iff (!nrst)
      (!pins_ff.nce && !$past(pins_ff.nce)) |-> $stable(pins_ff.byte_sel);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("width changed while selected");

  property p_accel;
    @(posedge mclk) disable iff (!nrst)
      accel_pin_ff && st_ff != ST_IDLE |-> cur_ff.op == OP_PROG;
  endproperty
  a_accel: assert property (p_accel) else $error("accel voltage outside programming");

  property p_sel_settled;
    @(posedge mclk) disable iff (!nrst) $fell(pins_ff.nce) |-> $stable(pins_ff.byte_sel);
  endproperty
  a_sel_settled: assert property (p_sel_settled) else $error("width moved as select fell");

  property p_rd_sample;
    @(posedge mclk) disable iff (!nrst)
      rd_valid_ff |-> !$past(pins_ff.noe) && !$past(pins_ff.nce);
  endproperty
  a_rd_sample: assert property (p_rd_sample) else $error("read taken with gate high");

  property p_we_width;
    @(posedge mclk) disable iff (!nrst) $fell(pins_ff.nwe) |-> !pins_ff.nwe [*4];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short");
endmodule : flash_bus_ctrl

// [rtl/flash_host_pkg.sv]
/*
  Shared constants and carriers for the parallel flash bus controller.
  Assumes a 100 MHz clock and an asynchronous NOR flash on the far side.
*/
package flash_host_pkg;
  localparam int ADDR_W       = 22;          // Word address width
  localparam int DATA_W       = 16;
  localparam int MCLK_PS      = 10000;       // Clock period in ps
  // Times in ns, counts rounded up to whole cycles
  localparam int ADDR_ACCESS_NS  = 70;       // address_access_time
  localparam int SELECT_ACCESS_NS = 70;      // select_access_time
  localparam int OE_ACCESS_NS    = 25;       // output_gate_access_time
  localparam int PAGE_ACCESS_NS  = 15;       // page_access_time
  localparam int WE_PULSE_NS     = 35;
  localparam int RECOVER_NS      = 20;
  localparam int ADDR_CYC  = (ADDR_ACCESS_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int SEL_CYC   = (SELECT_ACCESS_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int PAGE_CYC  = (PAGE_ACCESS_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int WE_CYC    = (WE_PULSE_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int REC_CYC   = (RECOVER_NS * 1000 + MCLK_PS - 1) / MCLK_PS;
  localparam int FULL_CYC  = (ADDR_CYC > SEL_CYC) ? ADDR_CYC : SEL_CYC;
  localparam int CNT_W     = 4;
  localparam int PAGE_LSB  = 3;              // Page select starts at address bit 3
  localparam int ECC_PAGE_LSB = 4;           // 32-byte correction page = 16 words
  localparam int BUF_MAX_WORDS = 128;        // Largest write buffer load
  localparam int BUF_CNT_W = 8;
  localparam int UNL_A1 = 22'h000555;        // Unlock sequence addresses (word mode)
  localparam int UNL_A2 = 22'h0002AA;
  localparam logic [15:0] UNL_D1 = 16'h00AA;
  localparam logic [15:0] UNL_D2 = 16'h0055;
  localparam logic [15:0] CMD_PROG = 16'h00A0;
  localparam logic [15:0] CMD_IDENT = 16'h0090;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_PROG  = 2'h2,   // Unlock + program word; short_prog or accel skips the unlock
    OP_IDENT = 2'h3    // Identification entry sequence
  } op_e;

  typedef struct packed {
    op_e                 op;
    logic                byte_mode;
    logic                short_prog;
    logic [ADDR_W:0]     addr;   // Bit 0 is the byte address bit in byte mode
    logic [DATA_W-1:0]   data;
  } req_s;

  typedef struct packed {
    logic              nce;
    logic              noe;
    logic              nwe;
    logic              byte_sel;
    logic [ADDR_W-1:0] addr;
  } pins_s;
endpackage : flash_host_pkg

// [verif/flash_bus_ctrl_tb_top.sv]
/*
  Self-checking bench for the flash bus controller and a flash model.
  Assumes every operation finishes well inside the wait bounds.
*/
`timescale 1ns/100ps
module flash_bus_ctrl_tb_top;
  import flash_host_pkg::*;
  logic        mclk, nrst, req_valid, req_ready, rd_valid_ff, wr_done_ff;
  logic        ecc_off, accel_req, accel_pin_ff, acc_seen;
  req_s        req;
  pins_s       pins_ff;
  logic [15:0] rd_data_ff, dq_out_ff, dq_oe_n_ff, dq_in, dev_dq, lfsr;
  logic [31:0] exp_q [$];
  logic [31:0] e;
  logic [15:0] shadow [int];
  int          n_fail, tests_run, n_wr;

  flash_bus_ctrl dut (.mclk(mclk), .nrst(nrst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .wr_done_ff(wr_done_ff), .ecc_off(ecc_off), .accel_req(accel_req),
    .accel_pin_ff(accel_pin_ff), .pins_ff(pins_ff), .dq_out_ff(dq_out_ff),
    .dq_oe_n_ff(dq_oe_n_ff), .dq_in(dq_in));
  flash_dev_model #(.ID_CODE(8'h3C)) dev (.p(pins_ff), .host_dq(dq_out_ff), .dq(dev_dq));
  // Each data line follows whichever party enables it
  assign dq_in = (~dq_oe_n_ff & dq_out_ff) | (dq_oe_n_ff & dev_dq);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] word_at(input logic [22:0] a);
    return shadow.exists(int'(a[22:1])) ? shadow[int'(a[22:1])] : a[16:1] ^ 16'h5A3C;
  endfunction : word_at

  task automatic cmp(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp

  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Request held until the edge that takes it; one idle edge before each
  task automatic send(input op_e op, input logic bm, sp, input logic [22:0] a,
                      input logic [15:0] d);
    int i;
    @(posedge mclk);
    #1;
    req = '{op, bm, sp, a, d};
    req_valid = 1'b1;
    for (i = 0; req_ready !== 1'b1; i++) begin
      if (i == 300) begin
        n_fail++;
        final_report();
      end
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
  endtask : send

  task automatic rd(input logic bm, id, input logic [22:0] a);
    logic [15:0] w, m;
    w = id ? 16'h003C : word_at(a);
    m = (bm || id) ? 16'h00FF : 16'hFFFF;
    if (bm) w = a[0] ? {8'h00, w[15:8]} : w;
    exp_q.push_back({m, w & m});
    send(OP_READ, bm, 1'b0, a, 16'h0000);
  endtask : rd

  // Any write kind; waits for its done pulse, then checks the page flag after a program
  task automatic wr(input op_e op, input logic sp, acc, input logic [22:0] a,
                    input logic ecc);
    int i, n0;
    lfsr = lfsr_next(lfsr);
    if (op == OP_PROG) shadow[int'(a[22:1])] = word_at(a) & lfsr;
    accel_req = acc;
    n0 = n_wr;
    send(op, 1'b0, sp, a, lfsr);
    for (i = 0; n_wr == n0; i++) begin
      if (i == 500) begin
        n_fail++;
        final_report();
      end
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
    accel_req = 1'b0;
    if (op == OP_PROG) cmp("ecc_off", {15'h0000, ecc}, {15'h0000, ecc_off});
  endtask : wr

  // Results are matched in order against the notes left by the drivers
  always @(posedge mclk) if (nrst) begin
    if (wr_done_ff === 1'b1) n_wr++;
    if (accel_pin_ff === 1'b1) acc_seen = 1'b1;
    if (accel_pin_ff === 1'b1 && accel_req !== 1'b1) cmp("accel_pin", 16'h0, 16'h1);
    if (rd_valid_ff === 1'b1) begin
      if (exp_q.size() == 0) cmp("rd_extra", 16'h0000, 16'h0001);
      else begin
        e = exp_q.pop_front();
        cmp("rd_data", e[15:0], rd_data_ff & e[31:16]);
      end
    end
  end

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    accel_req = 1'b0;
    req = '0;
    lfsr = 16'h000B;
    acc_seen = 1'b0;
    n_fail = 0;
    tests_run = 0;
    n_wr = 0;
    repeat (8) @(posedge mclk);
    #1 nrst = 1'b1;
    cmp("idle_pins", 16'h000F, {12'h000, pins_ff.nce, pins_ff.noe, pins_ff.nwe, pins_ff.byte_sel});
    cmp("idle_oe", 16'hFFFF, dq_oe_n_ff);
    rd(1'b0, 1'b0, 23'h000010);
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      rd(1'b0, 1'b0, {10'h000, lfsr[12:1], 1'b0});
    end
    for (int k = 0; k < 10; k++) rd(1'b0, 1'b0, 23'h000100 + 23'(2 * k));
    for (int k = 0; k < 4; k++) rd(1'b1, 1'b0, 23'h000040 + 23'(k));
    wr(OP_PROG, 1'b0, 1'b0, 23'h000200, 1'b0);
    wr(OP_PROG, 1'b1, 1'b0, 23'h000240, 1'b0);
    wr(OP_PROG, 1'b0, 1'b1, 23'h000280, 1'b0);
    cmp("accel_seen", 16'h0001, {15'h0000, acc_seen});
    wr(OP_PROG, 1'b1, 1'b0, 23'h00020A, 1'b1);
    rd(1'b0, 1'b0, 23'h000200);
    rd(1'b0, 1'b0, 23'h000240);
    rd(1'b0, 1'b0, 23'h000280);
    rd(1'b0, 1'b0, 23'h00020A);
    wr(OP_IDENT, 1'b0, 1'b0, 23'h000000, 1'b0);
    rd(1'b0, 1'b1, 23'h000000);
    for (int i = 0; exp_q.size() != 0; i++) begin
      if (i == 300) begin
        n_fail++;
        final_report();
      end
      @(posedge mclk);
    end
    final_report();
  end
endmodule : flash_bus_ctrl_tb_top

// [verif/flash_dev_model.sv]
/*
  Behavioural parallel flash standing on the far side of the controller.
  Assumes the bench resolves the data lines from the host's enables.
*/
`timescale 1ns/100ps
module flash_dev_model #(
  parameter logic [7:0] ID_CODE = 8'h3C  // Arbitrary identification value
) (
  input  wire flash_host_pkg::pins_s p,       // Control and address pins
  input  wire logic [15:0]           host_dq, // Host drive value
  output logic [15:0]                dq       // Device drive value
);
  import flash_host_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] last, w;
  logic        ident;
  logic [18:0] pg;
  realtime     t_ok, t_oe;
  int          a;

  initial begin
    last = 16'h0000;
    ident = 1'b0;
    dq = 16'h0000;
    pg = '0;
    t_ok = 0;
    t_oe = 0;
  end
  // A fresh page or a reselect pays the full access time
  always @(p.addr, p.nce) begin
    if (p.nce || p.addr[21:3] != pg) t_ok = $realtime + ADDR_ACCESS_NS;
    else if (t_ok < $realtime + PAGE_ACCESS_NS) t_ok = $realtime + PAGE_ACCESS_NS;
    pg = p.addr[21:3];
  end
  always @(negedge p.noe) t_oe = $realtime + OE_ACCESS_NS;
  // Reselecting always pays the select access time, even inside the old page
  always @(negedge p.nce) t_ok = $realtime + SELECT_ACCESS_NS;
  // Unsettled or released lines churn, so an early sample cannot match
  always #1 begin
    a = int'(p.addr);
    if (!p.nce && !p.noe && p.nwe && $realtime >= t_ok && $realtime >= t_oe) begin
      w = mem.exists(a) ? mem[a] : p.addr[15:0] ^ 16'h5A3C;
      if (ident) w = {~dq[15:8], ID_CODE};
      if (!p.byte_sel) w = {~dq[15:8], host_dq[15] ? w[15:8] : w[7:0]};
      dq = w;
    end else dq = ~dq;
  end
  // Command latch takes address and data at the strobe's rising edge
  always @(posedge p.nwe) if (!p.nce && p.noe) begin
    a = int'(p.addr);
    if (last == CMD_PROG) begin
      w = mem.exists(a) ? mem[a] : p.addr[15:0] ^ 16'h5A3C;
      mem[a] = w & host_dq; // Programming can only clear bits
      last = 16'h0000;
    end else begin
      if (host_dq == CMD_IDENT) ident = 1'b1;
      last = host_dq;
    end
  end
endmodule : flash_dev_model
